// ==== hdl/cmcc_core_stack.sv ====
// behavioural core stack: 512 words of 15 destructive-readout bits
// assumes drives come from the cycle controller on the same clock
`timescale 1ns/1ps
module cmcc_core_stack (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [cmcc_pkg::ADDR_W-1:0] addr_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [cmcc_pkg::DATA_W-1:0] inhibit_in,
	output logic [cmcc_pkg::DATA_W-1:0] sense_out
);
	// core array; not reset, cores keep their state without power
	logic [cmcc_pkg::DATA_W-1:0] mem [cmcc_pkg::DEPTH];
	logic read_d1_q; // read drive one cycle ago
	logic [cmcc_pkg::DATA_W-1:0] sense_q; // amplified switch pulses

	// remember read drive to find its leading edge
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			read_d1_q <= 1'b0;
		end else if (ce_in) begin
			read_d1_q <= read_in;
		end
	end

	// sense: ones that switch show while the read drive lasts
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sense_q <= cmcc_pkg::DATA_RST;
		end else if (ce_in) begin
			if (read_in && !read_d1_q) begin
				sense_q <= mem[addr_in];
			end else if (!read_in) begin
				sense_q <= cmcc_pkg::DATA_RST; // silent outside read
			end
		end
	end

	// read clears the word; write sets every uninhibited bit
	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			if (read_in) begin
				mem[addr_in] <= cmcc_pkg::DATA_RST;
			end else if (write_in) begin
				mem[addr_in] <= mem[addr_in] | ~inhibit_in;
			end
		end
	end

	assign sense_out = sense_q;
endmodule

// ==== hdl/cmcc_cycle_ctrl.sv ====
// core memory cycle controller: address, read, strobe, restore sequencing
// assumes the control section raises start_in for one cycle while idle,
// with address and data steady on req_in in that cycle
// Operation
// - store clears word, then writes it
// - inhibit zero bits throughout write phase
// - read drives every addressed bit to zero
// - sense path used only during read phase
// - every read followed by a restore
// - strobe loads sensed data into data register (on a store it loads the new word instead)
// - inhibit on when data bit is zero
// - write drive unconditional, data via inhibit
// - 512 words, 15 bits in parallel
// - address, read, strobe, then write enable
// - whole reference takes 8.0 us
`timescale 1ns/1ps
module cmcc_cycle_ctrl (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire cmcc_pkg::cmcc_req_t req_in,
	output cmcc_pkg::cmcc_drive_t drive_out,
	output logic busy_out,
	output logic done_out,
	output logic [cmcc_pkg::DATA_W-1:0] rdata_out
);
	cmcc_pkg::cmcc_phase_t phase_q; // current phase
	logic [7:0] cnt_q; // clocks since start
	logic busy_q; // a reference is running
	logic done_q; // one-cycle end pulse
	logic store_q; // request kind held for the cycle
	logic [cmcc_pkg::ADDR_W-1:0] addr_q; // held address
	logic [cmcc_pkg::DATA_W-1:0] wdata_q; // held store word
	logic [cmcc_pkg::DATA_W-1:0] z_q; // memory data register
	logic addr_en_q; // address enable
	logic read_en_q; // read drive
	logic strobe_q; // sense strobe
	logic write_en_q; // write drive
	logic [cmcc_pkg::DATA_W-1:0] inhibit_q; // per-bit inhibit
	logic [cmcc_pkg::DATA_W-1:0] sense; // from the stack
	logic [cmcc_pkg::DATA_W-1:0] sense_gated; // sense after read gating
	logic take; // request accepted this cycle
	logic last; // final clock of a reference

	// a new start is ignored while busy
	assign take = start_in && !busy_q;
	assign last = busy_q && (cnt_q == cmcc_pkg::CYC_CNT - 8'h01);

	// sense gated off outside read so write noise never lands in z
	assign sense_gated = read_en_q ? sense : cmcc_pkg::DATA_RST;

	// cycle counter and busy flag
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			busy_q <= 1'b0;
			cnt_q <= cmcc_pkg::CNT_RST;
			done_q <= 1'b0;
		end else if (ce_in) begin
			done_q <= last;
			if (take) begin
				busy_q <= 1'b1;
				cnt_q <= cmcc_pkg::CNT_RST;
			end else if (last) begin
				busy_q <= 1'b0;
			end else if (busy_q) begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	// phase tracking, mainly for visibility in waves
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			phase_q <= cmcc_pkg::PH_IDLE;
		end else if (ce_in) begin
			unique case (phase_q)
				cmcc_pkg::PH_IDLE: begin
					if (take) phase_q <= cmcc_pkg::PH_ADDR;
				end
				cmcc_pkg::PH_ADDR: begin
					if (cnt_q == cmcc_pkg::RD_ON_CNT) phase_q <= cmcc_pkg::PH_READ;
				end
				cmcc_pkg::PH_READ: begin
					if (cnt_q == cmcc_pkg::RD_OFF_CNT) phase_q <= cmcc_pkg::PH_GAP;
				end
				cmcc_pkg::PH_GAP: begin
					if (cnt_q == cmcc_pkg::WR_ON_CNT) phase_q <= cmcc_pkg::PH_WRITE;
				end
				cmcc_pkg::PH_WRITE: begin
					if (cnt_q == cmcc_pkg::WR_OFF_CNT) phase_q <= cmcc_pkg::PH_TAIL;
				end
				cmcc_pkg::PH_TAIL: begin
					if (last) phase_q <= cmcc_pkg::PH_IDLE;
				end
				// two spare codes of the 3-bit encoding fall back to idle
				default: begin
					phase_q <= cmcc_pkg::PH_IDLE;
				end
			endcase
		end
	end

	// capture request; address stays put for the whole reference
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			store_q <= 1'b0;
			addr_q <= cmcc_pkg::ADDR_RST;
			wdata_q <= cmcc_pkg::DATA_RST;
		end else if (ce_in && take) begin
			store_q <= req_in.store;
			addr_q <= req_in.addr;
			wdata_q <= req_in.wdata;
		end
	end

	// address enable first, held until the last clock
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			addr_en_q <= 1'b0;
		end else if (ce_in) begin
			addr_en_q <= take || (busy_q && !last);
		end
	end

	// read drive window; for a store this is the clear phase
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			read_en_q <= 1'b0;
		end else if (ce_in) begin
			read_en_q <= busy_q && (cnt_q >= cmcc_pkg::RD_ON_CNT)
				&& (cnt_q < cmcc_pkg::RD_OFF_CNT);
		end
	end

	// one strobe pulse inside the read window
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			strobe_q <= 1'b0;
		end else if (ce_in) begin
			strobe_q <= busy_q && (cnt_q == cmcc_pkg::STB_CNT);
		end
	end

	// memory data register: sensed word on fetch, new word on store
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			z_q <= cmcc_pkg::DATA_RST;
		end else if (ce_in && strobe_q) begin
			if (store_q) begin
				z_q <= wdata_q;
			end else begin
				z_q <= sense_gated;
			end
		end
	end

	// write drive: every read is always followed by this restore
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			write_en_q <= 1'b0;
		end else if (ce_in) begin
			write_en_q <= busy_q && (cnt_q >= cmcc_pkg::WR_ON_CNT)
				&& (cnt_q < cmcc_pkg::WR_OFF_CNT);
		end
	end

	// per-bit inhibit follows the inverted data register in write
	for (genvar b = 0; b < cmcc_pkg::DATA_W; b++) begin : g_inh
		always_ff @(posedge clk_in) begin
			if (!rst_n_in) begin
				inhibit_q[b] <= 1'b0;
			end else if (ce_in) begin
				inhibit_q[b] <= busy_q && (cnt_q >= cmcc_pkg::WR_ON_CNT)
					&& (cnt_q < cmcc_pkg::WR_OFF_CNT) && !z_q[b];
			end
		end
	end

	// the stack itself, all 15 bits in parallel
	cmcc_core_stack u_stack (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.addr_in(addr_q),
		.read_in(read_en_q),
		.write_in(write_en_q),
		.inhibit_in(inhibit_q),
		.sense_out(sense)
	);

	// outputs straight from flops
	// one driver for the whole struct, fields in declared order
	assign drive_out = {addr_en_q, read_en_q, strobe_q, write_en_q,
		inhibit_q};
	assign busy_out = busy_q;
	assign done_out = done_q;
	assign rdata_out = z_q;

	// helper: ce-qualified clocks spent busy, for the length check
	logic [7:0] h_len_q;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			h_len_q <= cmcc_pkg::CNT_RST;
		end else if (ce_in) begin
			if (take) h_len_q <= 8'h01;
			// the last clock drops busy, so it is not counted again
			else if (busy_q && !last) h_len_q <= h_len_q + 8'h01;
		end
	end

	// checks; ce low freezes the sequence, so the restore check holds off then and the load checks require ce
	AST_RD_AFTER_ADDR: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) $rose(read_en_q) |-> addr_en_q && !write_en_q)
		else $error("read enable without address enable");
	AST_STROBE_IN_READ: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) strobe_q |-> read_en_q && !write_en_q)
		else $error("strobe outside read phase");
	AST_RESTORE_FOLLOWS: assert property (@(posedge clk_in)
		disable iff (!rst_n_in || !ce_in)
		$fell(read_en_q) |-> ##[1:25] write_en_q)
		else $error("read not followed by restore");
	AST_INHIBIT_MATCH: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) write_en_q |-> inhibit_q == ~z_q)
		else $error("inhibit does not mirror data register");
	AST_INHIBIT_QUIET: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) !write_en_q |-> inhibit_q == 15'h0000)
		else $error("inhibit outside write phase");
	AST_CYCLE_LEN: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) done_q |-> h_len_q == cmcc_pkg::CYC_CNT)
		else $error("reference length wrong");
	AST_FETCH_LOAD: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		strobe_q && ce_in && !store_q |=> z_q == $past(sense))
		else $error("strobe did not load sensed word");
	AST_STORE_LOAD: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		strobe_q && ce_in && store_q |=> z_q == $past(wdata_q))
		else $error("store word not loaded");
	AST_NO_OVERLAP: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) !(read_en_q && write_en_q))
		else $error("read and write drive together");
	AST_ADDR_HELD: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		busy_q && $past(busy_q) |-> $stable(addr_q))
		else $error("address moved during reference");
	AST_PHASE_AGREE: assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		(read_en_q == (phase_q == cmcc_pkg::PH_READ))
		&& (write_en_q == (phase_q == cmcc_pkg::PH_WRITE)))
		else $error("drive windows disagree with phase");

	COV_FETCH: cover property (@(posedge clk_in) done_q && !store_q);
	COV_STORE: cover property (@(posedge clk_in) done_q && store_q);
	COV_ONES_SENSED: cover property (@(posedge clk_in)
		strobe_q && sense != 15'h0000);
	COV_BUSY_START: cover property (@(posedge clk_in) busy_q && start_in);
endmodule

// ==== pkg/cmcc_pkg.sv ====
// shared constants and types for the core memory cycle controller
// assumes a single 20 mhz clock and a 512 x 15 destructive-readout store
package cmcc_pkg;
	// store geometry
	localparam int ADDR_W = 9; // selects one of 512 words
	localparam int DATA_W = 15; // bits read and written in parallel
	localparam int DEPTH = 512; // words in the store

	// clock period in ns
	localparam int CLK_NS = 50;

	// cycle landmarks in ns from the start of a reference
	localparam int CYCLE_NS = 8000; // one full reference
	localparam int RD_ON_NS = 250; // read drive follows address enable
	localparam int STROBE_NS = 2500; // readout time
	localparam int RD_OFF_NS = 3000; // end of read drive
	localparam int WR_ON_NS = 4000; // start of write or restore drive
	localparam int WR_OFF_NS = 6000; // end of write drive

	// landmarks as clock counts; starts round up, lengths round down
	localparam logic [7:0] CYC_CNT = 8'(CYCLE_NS / CLK_NS);
	localparam logic [7:0] RD_ON_CNT = 8'((RD_ON_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] STB_CNT = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RD_OFF_CNT = 8'(RD_OFF_NS / CLK_NS);
	localparam logic [7:0] WR_ON_CNT = 8'((WR_ON_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] WR_OFF_CNT = 8'(WR_OFF_NS / CLK_NS);

	// reset values
	localparam logic [DATA_W-1:0] DATA_RST = 15'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
	localparam logic [7:0] CNT_RST = 8'h00;

	// request from the control section
	typedef struct packed {
		logic store; // 1 = store new word, 0 = fetch
		logic [ADDR_W-1:0] addr; // word address
		logic [DATA_W-1:0] wdata; // word to store
	} cmcc_req_t;

	// drive signals toward the stack
	typedef struct packed {
		logic addr_en; // address selection active
		logic read_en; // read or clear drive
		logic strobe; // sense sample point
		logic write_en; // write or restore drive, all bits
		logic [DATA_W-1:0] inhibit; // per-bit inhibit, high = leave zero
	} cmcc_drive_t;

	// sequencer phases
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_ADDR,
		PH_READ,
		PH_GAP,
		PH_WRITE,
		PH_TAIL
	} cmcc_phase_t;
endpackage

// ==== verification/cmcc_ctl_model.sv ====
// control section model: hands requests to the cycle controller
// assumes the controller's clock and synchronous active-low reset
`timescale 1ns/1ps
module cmcc_ctl_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic go_in,
	input wire logic rude_in,
	input wire logic busy_in,
	input wire cmcc_pkg::cmcc_req_t req_in,
	output logic start_out,
	output cmcc_pkg::cmcc_req_t req_out
);
	// one-cycle start while idle; rude ignores busy for refusal tests
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			start_out <= 1'b0;
			req_out <= '0;
		end else begin
			start_out <= go_in && !start_out && (!busy_in || rude_in);
			// word steady with start, scrambled once taken
			if (go_in && !start_out) begin
				req_out <= req_in;
			end else begin
				req_out <= ~req_out;
			end
		end
	end
endmodule

// ==== verification/core_memory_cycle_control_tb_top.sv ====
// self-checking bench for the core memory cycle controller
// assumes the stack lives inside the controller and a 20 mhz clock
`timescale 1ns/1ps
module core_memory_cycle_control_tb_top;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ce_in = 1'b1;
	logic go = 1'b0;
	logic rude = 1'b0;
	cmcc_pkg::cmcc_req_t mreq = '0;
	cmcc_pkg::cmcc_req_t req;
	cmcc_pkg::cmcc_drive_t drv;
	logic start;
	logic busy;
	logic done;
	logic [cmcc_pkg::DATA_W-1:0] rdata;
	int n_fail = 0;
	int cmp_count = 0;
	int tick = 0;

	always #25 clk_in = ~clk_in;

	cmcc_ctl_model ctl (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go),
		.rude_in(rude), .busy_in(busy), .req_in(mreq), .start_out(start),
		.req_out(req));
	cmcc_cycle_ctrl uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
		.start_in(start), .req_in(req), .drive_out(drv), .busy_out(busy),
		.done_out(done), .rdata_out(rdata));

	task automatic wrap_up();
		$display("compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		chk_word(32'(got), 32'(exp));
	endtask

	// hang guard, well above eight references
	always @(posedge clk_in) begin
		tick <= tick + 1;
		if (tick == 4000) begin
			n_fail++;
			wrap_up();
		end
	end

	// queue a request in the model; call just after a rising edge
	task automatic ask(input logic st, input logic [8:0] a,
		input logic [14:0] w);
		mreq <= '{store: st, addr: a, wdata: w};
		go <= 1'b1;
	endtask

	// one reference: times every landmark in enabled edges from the take
	task automatic do_ref(input logic [14:0] exp, input int gap,
		input bit rb, input bit nx, input logic ns, input logic [8:0] na,
		input logic [14:0] nw);
		int k = 0;
		int rd0 = 0;
		int n_rd = 0;
		int stb = 0;
		int n_stb = 0;
		int wr0 = 0;
		int n_wr = 0;
		int n_ae = 0;
		int bad = 0;
		int g;
		logic ces;
		logic [14:0] prv;
		g = gap;
		prv = rdata;
		do @(posedge clk_in); while (start !== 1'b1);
		go <= 1'b0;
		while (k < 400) begin
			ces = ce_in;
			// freeze a stretch of the read phase
			if (k >= 20 && g > 0) begin
				ce_in <= 1'b0;
				g--;
			end else begin
				ce_in <= 1'b1;
			end
			rude <= (rb && k == 40);
			if (rb && k == 40)
				ask(1'b1, 9'h0aa, 15'h7fff);
			if (rb && k == 41)
				go <= 1'b0;
			if (nx && k == 150)
				ask(ns, na, nw);
			@(negedge clk_in);
			if (ces) begin
				k++;
				if (drv.read_en === 1'b1 && rd0 == 0)
					rd0 = k;
				n_rd += (drv.read_en === 1'b1);
				if (drv.strobe === 1'b1)
					stb = k;
				n_stb += (drv.strobe === 1'b1);
				if (drv.write_en === 1'b1 && wr0 == 0)
					wr0 = k;
				n_wr += (drv.write_en === 1'b1);
				n_ae += (drv.addr_en === 1'b1);
				if (drv.inhibit !== ((drv.write_en === 1'b1) ? ~exp : 15'h0000))
					bad++;
				if (drv.read_en === 1'b1 && drv.write_en === 1'b1)
					bad++;
				if (k != 53 && rdata !== prv)
					bad++;
				if (k == 1 && busy !== 1'b1)
					bad++;
				prv = rdata;
				if (done === 1'b1)
					break;
			end
			@(posedge clk_in);
		end
		chk_cnt(rd0, 7);
		chk_cnt(n_rd, 55);
		chk_cnt(stb, 52);
		chk_cnt(n_stb, 1);
		chk_cnt(wr0, 82);
		chk_cnt(n_wr, 40);
		chk_cnt(n_ae, 160);
		chk_cnt(k, 161);
		chk_cnt(bad, 0);
		chk_word(32'(rdata), 32'(exp));
	endtask

	// all outputs low while reset is held
	task automatic sc_reset();
		repeat (5) @(posedge clk_in);
		// look at settled outputs, away from the launching edge
		@(negedge clk_in);
		chk_word(32'({drv, busy, done}), 32'h0);
		chk_word(32'(rdata), 32'h0);
		@(posedge clk_in);
		rst_n_in <= 1'b1;
	endtask

	// extreme addresses, all-ones and all-zeros, back to back
	task automatic sc_store_fetch();
		@(posedge clk_in);
		ask(1'b1, 9'h000, 15'h7fff);
		do_ref(15'h7fff, 0, 0, 1, 1'b1, 9'h1ff, 15'h0000);
		do_ref(15'h0000, 0, 0, 1, 1'b0, 9'h000, 15'h2aaa);
		do_ref(15'h7fff, 0, 0, 1, 1'b0, 9'h000, 15'h0000);
		do_ref(15'h7fff, 0, 0, 1, 1'b0, 9'h1ff, 15'h7fff);
		do_ref(15'h0000, 0, 0, 0, 1'b0, 9'h000, 15'h0000);
	endtask

	// start while busy ignored, stall, then overwrite needs a clear
	task automatic sc_refuse_rewrite();
		@(posedge clk_in);
		ask(1'b1, 9'h0aa, 15'h5555);
		do_ref(15'h5555, 7, 1, 1, 1'b1, 9'h0aa, 15'h2aaa);
		do_ref(15'h2aaa, 0, 0, 1, 1'b0, 9'h0aa, 15'h7fff);
		do_ref(15'h2aaa, 0, 0, 0, 1'b0, 9'h000, 15'h0000);
	endtask

	initial begin
		sc_reset();
		sc_store_fetch();
		sc_refuse_rewrite();
		wrap_up();
	end
endmodule
